// file: jmmcfg_bank.sv
// configuration register banks for joystick, music, voltage and temp units
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps

module jmmcfg_bank (
    input wire logic mclk_i,                     // 125 MHz clock
    input wire logic resetn_i,                   // async reset, active low
    input wire logic [11:0] avs_address_i,       // byte address
    input wire logic avs_read_i,                 // read request
    input wire logic avs_write_i,                // write request
    input wire logic [3:0] avs_byteenable_i,     // byte lanes
    input wire logic [31:0] avs_writedata_i,     // write data
    output logic [31:0] avs_readdata_o,          // read data
    output logic avs_waitrequest_o,              // stall
    input wire logic [3:0] unit_irq_i,           // per-unit irq request
    input wire logic temp_over_temp_n_i,         // sensor over-temp, low
    input wire logic temp_smi_i,                 // sensor mgmt request
    input wire logic vmon_over_temp_n_i,         // thermistor over-temp
    input wire logic vmon_smi_i,                 // thermistor mgmt req
    input wire logic stick_pins_sel_i,           // pins in joystick use
    output jmmcfg_pkg::jmmcfg_bank_out_t [3:0] bank_cfg_o, // bank setup
    output logic [3:0] irq_req_o,                // gated irq requests
    output logic over_temp_output_n_o,           // over-temp pin, low
    output logic system_management_request_o,   // routed mgmt request
    output logic [3:0] stick_button_pullup_o,    // button pull-ups
    output logic music_receive_data_pullup_o,    // receive pull-up
    output logic music_out_float_o               // float music outputs
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    jmmcfg_pkg::jmmcfg_state_t st;
    jmmcfg_pkg::jmmcfg_state_t next_st;

    logic [1:0] sel_bank;
    logic [7:0] sel_idx;
    logic sel_open;
    logic [7:0] rd_val;
    logic [7:0] wr_byte;
    logic wr_lane;

    // ------------------------------------------------------------------
    // reset image
    // ------------------------------------------------------------------
    function automatic jmmcfg_pkg::jmmcfg_state_t reset_image();
        jmmcfg_pkg::jmmcfg_state_t s;
        s = '0;
        s.phase = jmmcfg_pkg::JMM_IDLE;
        s.rdata = jmmcfg_pkg::ZERO_BYTE;
        for (int b = 0; b < jmmcfg_pkg::NBANK; b++)
        begin
            s.bank[b].active = jmmcfg_pkg::ACTIVATE_RST[jmmcfg_pkg::ACT_BIT];
            s.bank[b].base_high = jmmcfg_pkg::BASE_HIGH_RST[b];
            s.bank[b].base_low = jmmcfg_pkg::BASE_LOW_RST[b];
            s.bank[b].irq_select = jmmcfg_pkg::IRQ_SELECT_RST;
            s.bank[b].irq_type_rw =
                jmmcfg_pkg::IRQ_TYPE_RST[jmmcfg_pkg::IRQ_TYPE_RW_BIT];
        end
        s.joy_pullup = jmmcfg_pkg::PIN_CONFIG_RST[jmmcfg_pkg::PULLUP_BIT];
        s.mus_pullup = jmmcfg_pkg::PIN_CONFIG_RST[jmmcfg_pkg::PULLUP_BIT];
        s.mus_float = jmmcfg_pkg::PIN_CONFIG_RST[jmmcfg_pkg::FLOAT_BIT];
        return s;
    endfunction : reset_image

    // constant image, so the async reset branch loads constants only
    localparam jmmcfg_pkg::jmmcfg_state_t ST_RST = reset_image();

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    assign sel_bank = avs_address_i[jmmcfg_pkg::BANK_LSB +: 2];
    assign sel_idx = avs_address_i[jmmcfg_pkg::IDX_LSB +: 8];
    assign wr_byte = avs_writedata_i[7:0];
    assign wr_lane = avs_byteenable_i[0];

    assign sel_open = st.bank[sel_bank].active ||
        (sel_idx == jmmcfg_pkg::IDX_ACTIVATE);

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_val = jmmcfg_pkg::ZERO_BYTE;
        if (sel_open)
        begin
            case (sel_idx)
                jmmcfg_pkg::IDX_ACTIVATE:
                begin
                    rd_val[jmmcfg_pkg::ACT_BIT] = st.bank[sel_bank].active;
                end
                jmmcfg_pkg::IDX_BASE_HIGH:
                begin
                    rd_val = st.bank[sel_bank].base_high;
                end
                jmmcfg_pkg::IDX_BASE_LOW:
                begin
                    rd_val = st.bank[sel_bank].base_low &
                        jmmcfg_pkg::BASE_LOW_WMASK[sel_bank];
                end
                jmmcfg_pkg::IDX_IRQ_SELECT:
                begin
                    rd_val = st.bank[sel_bank].irq_select;
                end
                jmmcfg_pkg::IDX_IRQ_TYPE:
                begin
                    rd_val = jmmcfg_pkg::IRQ_TYPE_RST;
                    rd_val[jmmcfg_pkg::IRQ_TYPE_RW_BIT] =
                        st.bank[sel_bank].irq_type_rw;
                end
                jmmcfg_pkg::IDX_DMA_REPORT_A,
                jmmcfg_pkg::IDX_DMA_REPORT_B:
                begin
                    rd_val = jmmcfg_pkg::DMA_NONE;
                end
                jmmcfg_pkg::IDX_PIN_CONFIG:
                begin
                    if (sel_bank == jmmcfg_pkg::BANK_JOY)
                    begin
                        rd_val[jmmcfg_pkg::PULLUP_BIT] = st.joy_pullup;
                    end
                    else if (sel_bank == jmmcfg_pkg::BANK_MUS)
                    begin
                        rd_val[jmmcfg_pkg::PULLUP_BIT] = st.mus_pullup;
                        rd_val[jmmcfg_pkg::FLOAT_BIT] = st.mus_float;
                    end
                end
                default:
                begin
                    rd_val = jmmcfg_pkg::ZERO_BYTE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // bus sequencing and register writes
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        case (st.phase)
            jmmcfg_pkg::JMM_IDLE:
            begin
                if (avs_read_i || avs_write_i)
                begin
                    next_st.rdata = avs_read_i ? rd_val : jmmcfg_pkg::ZERO_BYTE;
                    next_st.phase = jmmcfg_pkg::JMM_DONE;
                end
            end
            jmmcfg_pkg::JMM_DONE:
            begin
                next_st.phase = jmmcfg_pkg::JMM_IDLE;
                if (avs_write_i && wr_lane && sel_open)
                begin
                    case (sel_idx)
                        jmmcfg_pkg::IDX_ACTIVATE:
                        begin
                            next_st.bank[sel_bank].active =
                                wr_byte[jmmcfg_pkg::ACT_BIT];
                        end
                        jmmcfg_pkg::IDX_BASE_HIGH:
                        begin
                            next_st.bank[sel_bank].base_high = wr_byte;
                        end
                        jmmcfg_pkg::IDX_BASE_LOW:
                        begin
                            next_st.bank[sel_bank].base_low = wr_byte &
                                jmmcfg_pkg::BASE_LOW_WMASK[sel_bank];
                        end
                        jmmcfg_pkg::IDX_IRQ_SELECT:
                        begin
                            next_st.bank[sel_bank].irq_select = wr_byte;
                        end
                        jmmcfg_pkg::IDX_IRQ_TYPE:
                        begin
                            next_st.bank[sel_bank].irq_type_rw =
                                wr_byte[jmmcfg_pkg::IRQ_TYPE_RW_BIT];
                        end
                        jmmcfg_pkg::IDX_PIN_CONFIG:
                        begin
                            if (sel_bank == jmmcfg_pkg::BANK_JOY)
                            begin
                                next_st.joy_pullup =
                                    wr_byte[jmmcfg_pkg::PULLUP_BIT];
                            end
                            else if (sel_bank == jmmcfg_pkg::BANK_MUS)
                            begin
                                next_st.mus_pullup =
                                    wr_byte[jmmcfg_pkg::PULLUP_BIT];
                                next_st.mus_float =
                                    wr_byte[jmmcfg_pkg::FLOAT_BIT];
                            end
                        end
                        default:
                        begin
                            next_st = next_st;
                        end
                    endcase
                end
            end
            default:
            begin
                next_st.phase = jmmcfg_pkg::JMM_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st <= ST_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // bus outputs
    // ------------------------------------------------------------------
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) &&
        (st.phase != jmmcfg_pkg::JMM_DONE);
    assign avs_readdata_o = {24'h000000, st.rdata};

    // ------------------------------------------------------------------
    // per-bank setup and interrupt gating
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < jmmcfg_pkg::NBANK; g++)
        begin : g_bank
            logic req;
            if (g == int'(jmmcfg_pkg::BANK_TEMP))
            begin : g_temp
                assign req = unit_irq_i[g] || temp_smi_i || vmon_smi_i;
            end
            else
            begin : g_plain
                assign req = unit_irq_i[g];
            end
            assign irq_req_o[g] = st.bank[g].active && req;
            assign bank_cfg_o[g].active = st.bank[g].active;
            assign bank_cfg_o[g].base_addr = {st.bank[g].base_high,
                st.bank[g].base_low & jmmcfg_pkg::BASE_LOW_WMASK[g]};
            assign bank_cfg_o[g].irq_num =
                st.bank[g].irq_select[jmmcfg_pkg::IRQ_NUM_MSB:0];
            // wake-up enable only for joystick and music
            assign bank_cfg_o[g].wake_en = (g < int'(jmmcfg_pkg::BANK_VMON)) &&
                st.bank[g].irq_select[jmmcfg_pkg::WAKE_BIT];
            assign bank_cfg_o[g].irq_type_rw = st.bank[g].irq_type_rw;
        end
    endgenerate

    // ------------------------------------------------------------------
    // sensor routing; the alert signal has no destination
    // ------------------------------------------------------------------
    // over-temp to pin
    assign over_temp_output_n_o = !(st.bank[jmmcfg_pkg::BANK_TEMP].active &&
        (!temp_over_temp_n_i || !vmon_over_temp_n_i));
    assign system_management_request_o =
        st.bank[jmmcfg_pkg::BANK_TEMP].active && (temp_smi_i || vmon_smi_i);

    // ------------------------------------------------------------------
    // pin controls
    // ------------------------------------------------------------------
    // pull-ups in joystick use
    assign stick_button_pullup_o = {4{st.joy_pullup && stick_pins_sel_i}};
    assign music_receive_data_pullup_o = st.mus_pullup;
    assign music_out_float_o = st.mus_float &&
        !st.bank[jmmcfg_pkg::BANK_MUS].active;

endmodule : jmmcfg_bank

// file: jmmcfg_pkg.sv
// constants and types for the joystick, music and monitor config banks
package jmmcfg_pkg;

    // ------------------------------------------------------------------
    // bank selection and bus address layout
    // ------------------------------------------------------------------
    localparam int NBANK = 4;
    localparam int ADDR_W = 12;
    localparam int BANK_LSB = 10;
    localparam int IDX_LSB = 2;
    localparam logic [1:0] BANK_JOY = 2'h0;
    localparam logic [1:0] BANK_MUS = 2'h1;
    localparam logic [1:0] BANK_VMON = 2'h2;
    localparam logic [1:0] BANK_TEMP = 2'h3;

    // ------------------------------------------------------------------
    // register indexes (byte address = 4 * index within a bank)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW = 8'h61;
    localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
    localparam logic [7:0] IDX_DMA_REPORT_A = 8'h74;
    localparam logic [7:0] IDX_DMA_REPORT_B = 8'h75;
    localparam logic [7:0] IDX_PIN_CONFIG = 8'hF0;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int ACT_BIT = 0;
    localparam int IRQ_TYPE_RW_BIT = 1;
    localparam int WAKE_BIT = 4;
    localparam int IRQ_NUM_MSB = 3;
    localparam int PULLUP_BIT = 2;
    localparam int FLOAT_BIT = 0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ACTIVATE_RST = 8'h00;
    localparam logic [7:0] IRQ_SELECT_RST = 8'h00;
    localparam logic [7:0] IRQ_TYPE_RST = 8'h03;
    localparam logic [7:0] DMA_NONE = 8'h04;
    localparam logic [7:0] PIN_CONFIG_RST = 8'h00;
    // per-bank tables, element 0 is the joystick bank
    localparam logic [3:0][7:0] BASE_HIGH_RST = {8'h00, 8'h00, 8'h03, 8'h02};
    localparam logic [3:0][7:0] BASE_LOW_RST = {8'h00, 8'h00, 8'h30, 8'h00};
    localparam logic [3:0][7:0] BASE_LOW_WMASK = {8'hF0, 8'hF0, 8'hFC, 8'hF0};

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        JMM_IDLE = 2'b01,
        JMM_DONE = 2'b10
    } jmmcfg_phase_t;

    typedef struct packed {
        logic active;
        logic [7:0] base_high;
        logic [7:0] base_low;
        logic [7:0] irq_select;
        logic irq_type_rw;
    } jmmcfg_bank_t;

    typedef struct packed {
        jmmcfg_phase_t phase;
        logic [7:0] rdata;
        jmmcfg_bank_t [3:0] bank;
        logic joy_pullup;
        logic mus_pullup;
        logic mus_float;
    } jmmcfg_state_t;

    typedef struct packed {
        logic active;
        logic [15:0] base_addr;
        logic [3:0] irq_num;
        logic wake_en;
        logic irq_type_rw;
    } jmmcfg_bank_out_t;

endpackage : jmmcfg_pkg

// file: jmmcfg_bank_chk.sv
// port checker for the config banks, bound to the bank module below
`timescale 1ns/100ps
module jmmcfg_bank_chk (
    input wire logic mclk_i, // clock
    input wire logic resetn_i, // reset, low
    input wire logic [11:0] avs_address_i, // address
    input wire logic avs_read_i, // read
    input wire logic avs_write_i, // write
    input wire logic [31:0] avs_readdata_o, // read data
    input wire logic avs_waitrequest_o, // stall
    input wire logic [3:0] unit_irq_i, // unit irq
    input wire logic temp_over_temp_n_i, // sensor hot
    input wire logic temp_smi_i, // sensor req
    input wire logic vmon_over_temp_n_i, // monitor hot
    input wire logic vmon_smi_i, // monitor req
    input wire logic stick_pins_sel_i, // pin use
    input wire jmmcfg_pkg::jmmcfg_bank_out_t [3:0] bank_cfg_o, // setup
    input wire logic [3:0] irq_req_o, // irq out
    input wire logic over_temp_output_n_o, // hot pin
    input wire logic system_management_request_o, // req out
    input wire logic [3:0] stick_button_pullup_o, // pull-ups
    input wire logic music_out_float_o // float
);
    logic [1:0] bs;
    logic [7:0] ix;
    logic ans;
    logic on3;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    assign bs = avs_address_i[11:10];
    assign ix = avs_address_i[9:2];
    assign ans = avs_read_i && !avs_waitrequest_o;
    assign on3 = bank_cfg_o[3].active;
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_blocked_read: assert property (ans && !bank_cfg_o[bs].active
        && ix != 8'h30 |-> avs_readdata_o == 32'h0)
        else $error("blocked read");
    a_blocked_write: assert property (avs_write_i && !avs_waitrequest_o
        && !bank_cfg_o[bs].active && ix != 8'h30 |=> $stable(bank_cfg_o))
        else $error("blocked write changed setup");
    a_dma_none: assert property (ans && bank_cfg_o[bs].active
        && ix[7:1] == 7'h3A |-> avs_readdata_o == 32'h4) else $error("dma");
    a_type_fixed: assert property (ans && bank_cfg_o[bs].active
        && ix == 8'h71 |-> (avs_readdata_o | 32'h2) == 32'h3)
        else $error("type");
    a_base_align: assert property ({bank_cfg_o[0].base_addr[3:0],
        bank_cfg_o[1].base_addr[1:0], bank_cfg_o[2].base_addr[3:0],
        bank_cfg_o[3].base_addr[3:0]} == 14'h0) else $error("base align");
    a_float_inact: assert property (music_out_float_o
        |-> !bank_cfg_o[1].active) else $error("float while active");
    a_over_temp: assert property (over_temp_output_n_o ==
        !(on3 && !(temp_over_temp_n_i && vmon_over_temp_n_i)))
        else $error("hot");
    a_mgmt_route: assert property (system_management_request_o ==
        (on3 && (temp_smi_i || vmon_smi_i))) else $error("mgmt route");
    a_sensor_irq: assert property (irq_req_o[3] == (on3
        && (unit_irq_i[3] || temp_smi_i || vmon_smi_i))) else $error("irq3");
    a_pullup_gate: assert property (|stick_button_pullup_o
        |-> stick_pins_sel_i && &stick_button_pullup_o) else $error("pullup");
endmodule : jmmcfg_bank_chk

bind jmmcfg_bank jmmcfg_bank_chk chk_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .unit_irq_i(unit_irq_i), .temp_over_temp_n_i(temp_over_temp_n_i),
    .temp_smi_i(temp_smi_i), .vmon_over_temp_n_i(vmon_over_temp_n_i),
    .vmon_smi_i(vmon_smi_i), .stick_pins_sel_i(stick_pins_sel_i),
    .bank_cfg_o(bank_cfg_o), .irq_req_o(irq_req_o),
    .over_temp_output_n_o(over_temp_output_n_o),
    .system_management_request_o(system_management_request_o),
    .stick_button_pullup_o(stick_button_pullup_o),
    .music_out_float_o(music_out_float_o)
);

// file: testbench.sv
// self-checking bench for the config banks
`timescale 1ns/100ps
module testbench;
    logic mclk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [11:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [3:0] unit_irq_i, irq_req_o, stick_button_pullup_o;
    logic temp_over_temp_n_i, temp_smi_i, vmon_over_temp_n_i, vmon_smi_i;
    logic stick_pins_sel_i, over_temp_output_n_o, music_out_float_o;
    logic system_management_request_o, music_receive_data_pullup_o;
    jmmcfg_pkg::jmmcfg_bank_out_t [3:0] bank_cfg_o;
    int err_total = 0;
    int tests_run = 0;
    logic [7:0] hi [4] = '{8'h02, 8'h03, 8'h00, 8'h00};
    logic [7:0] lo [4] = '{8'h00, 8'h30, 8'h00, 8'h00};
    logic [7:0] msk [4] = '{8'hF0, 8'hFC, 8'hF0, 8'hF0};

    jmmcfg_bank dut_u (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(4'hF), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .unit_irq_i(unit_irq_i), .temp_over_temp_n_i(temp_over_temp_n_i),
        .temp_smi_i(temp_smi_i), .vmon_over_temp_n_i(vmon_over_temp_n_i),
        .vmon_smi_i(vmon_smi_i), .stick_pins_sel_i(stick_pins_sel_i),
        .bank_cfg_o(bank_cfg_o), .irq_req_o(irq_req_o),
        .over_temp_output_n_o(over_temp_output_n_o),
        .system_management_request_o(system_management_request_o),
        .stick_button_pullup_o(stick_button_pullup_o),
        .music_receive_data_pullup_o(music_receive_data_pullup_o),
        .music_out_float_o(music_out_float_o)
    );

    initial
    begin
        mclk_i = 1'h0;
        forever #4 mclk_i = ~mclk_i;
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input int b, input logic [7:0] x,
        input logic [7:0] d);
        int n;
        logic late;
        n = 0;
        @(posedge mclk_i);
        avs_address_i <= {b[1:0], x, 2'h0};
        avs_writedata_i <= {24'h000000, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        // settled values mid-cycle hold up to the next rising edge
        do
        begin
            @(negedge mclk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'h0 && n < 20);
        q = avs_readdata_o;
        late = (avs_waitrequest_o !== 1'h0);
        // the edge that sees waitrequest low completes the transfer
        @(posedge mclk_i);
        avs_write_i <= 1'h0;
        avs_read_i <= 1'h0;
        if (late)
        begin
            err_total++;
            print_verdict();
        end
    endtask : bus

    task automatic wr(input int b, input logic [7:0] x, input logic [7:0] d);
        bus(1'h1, b, x, d);
    endtask : wr

    task automatic rc(input int b, input logic [7:0] x, input logic [7:0] e);
        bus(1'h0, b, x, 8'h00);
        chk($sformatf("bank%0d idx %h", b, x), {24'h000000, e}, q);
    endtask : rc
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int b = 0; b < 4; b++)
        begin
            rc(b, 8'h60, 8'h00);
            rc(b, 8'h30, 8'h00);
            wr(b, 8'h30, 8'hFF);
            rc(b, 8'h30, 8'h01);
            chk("active", 32'h1, 32'(bank_cfg_o[b].active));
            rc(b, 8'h60, hi[b]);
            rc(b, 8'h61, lo[b]);
            rc(b, 8'h70, 8'h00);
            rc(b, 8'h71, 8'h03);
            rc(b, 8'hF0, 8'h00);
            rc(b, 8'h10, 8'h00);
        end
        $display("reset values test done");
    endtask : t_reset

    task automatic t_mask();
        for (int b = 0; b < 4; b++)
        begin
            wr(b, 8'h60, hi[b]); // base in decode window
            wr(b, 8'h61, 8'hFF);
            rc(b, 8'h61, msk[b]);
            q = 32'(bank_cfg_o[b].base_addr);
            chk("base", {16'h0, hi[b], msk[b]}, q);
            wr(b, 8'h71, 8'hFF);
            rc(b, 8'h71, 8'h03);
            chk("type", 32'h1, 32'(bank_cfg_o[b].irq_type_rw));
            wr(b, 8'h71, 8'h00);
            rc(b, 8'h71, 8'h01);
            chk("type", 32'h0, 32'(bank_cfg_o[b].irq_type_rw));
            wr(b, 8'h74, 8'h00);
            wr(b, 8'h75, 8'hFF);
            rc(b, 8'h74, 8'h04);
            rc(b, 8'h75, 8'h04);
            wr(b, 8'h70, 8'h1A);
            rc(b, 8'h70, 8'h1A);
            chk("irq num", 32'hA, 32'(bank_cfg_o[b].irq_num));
            chk("wake", 32'(b < 2), 32'(bank_cfg_o[b].wake_en));
        end
        $display("mask test done");
    endtask : t_mask

    task automatic t_pins();
        unit_irq_i <= 4'hF;
        wr(0, 8'h30, 8'h00);
        @(negedge mclk_i);
        chk("irq", 32'hE, 32'(irq_req_o));
        wr(0, 8'h70, 8'h05);
        wr(0, 8'h30, 8'h01);
        rc(0, 8'h70, 8'h1A);
        unit_irq_i <= 4'h0;
        wr(0, 8'hF0, 8'hFF);
        rc(0, 8'hF0, 8'h04);
        stick_pins_sel_i <= 1'h1;
        @(negedge mclk_i);
        chk("pullup", 32'hF, 32'(stick_button_pullup_o));
        @(posedge mclk_i);
        stick_pins_sel_i <= 1'h0;
        @(negedge mclk_i);
        chk("pullup", 32'h0, 32'(stick_button_pullup_o));
        wr(1, 8'hF0, 8'hFF);
        rc(1, 8'hF0, 8'h05);
        chk("rx pull", 32'h1, 32'(music_receive_data_pullup_o));
        chk("float", 32'h0, 32'(music_out_float_o));
        wr(1, 8'h30, 8'h00);
        wr(1, 8'hF0, 8'h00);
        @(negedge mclk_i);
        chk("float", 32'h1, 32'(music_out_float_o));
        wr(1, 8'h30, 8'h01);
        rc(1, 8'hF0, 8'h05);
        wr(1, 8'hF0, 8'h00);
        @(negedge mclk_i);
        chk("rx pull", 32'h0, 32'(music_receive_data_pullup_o));
        $display("pin control test done");
    endtask : t_pins

    task automatic t_temp();
        @(posedge mclk_i);
        temp_over_temp_n_i <= 1'h0;
        temp_smi_i <= 1'h1; // source enabled in sensor
        @(negedge mclk_i);
        chk("hot pin", 32'h0, 32'(over_temp_output_n_o));
        chk("mgmt", 32'h1, 32'(system_management_request_o));
        @(posedge mclk_i);
        temp_over_temp_n_i <= 1'h1;
        temp_smi_i <= 1'h0;
        vmon_over_temp_n_i <= 1'h0;
        vmon_smi_i <= 1'h1; // source enabled in monitor
        @(negedge mclk_i);
        chk("hot pin", 32'h0, 32'(over_temp_output_n_o));
        chk("irq", 32'h8, 32'(irq_req_o));
        wr(3, 8'h30, 8'h00);
        @(negedge mclk_i);
        chk("hot pin", 32'h1, 32'(over_temp_output_n_o));
        chk("mgmt", 32'h0, 32'(system_management_request_o));
        $display("sensor routing test done");
    endtask : t_temp

    initial
    begin
        resetn_i = 1'h0;
        avs_address_i = 12'h000;
        avs_read_i = 1'h0;
        avs_write_i = 1'h0;
        avs_writedata_i = 32'h0;
        unit_irq_i = 4'h0;
        temp_over_temp_n_i = 1'h1;
        vmon_over_temp_n_i = 1'h1;
        temp_smi_i = 1'h0;
        vmon_smi_i = 1'h0;
        stick_pins_sel_i = 1'h0;
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'h1;
        t_reset();
        t_mask();
        t_pins();
        t_temp();
        print_verdict();
    end
endmodule : testbench
